// *** hdl/scpa_mod_serial.sv ***
`timescale 1ns/1ps
module scpa_mod_serial (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [63:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [15:0] remainder
);

  logic [63:0] dvd_r;
  logic [15:0] rem_r;
  logic [6:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [16:0] trial;
  logic [16:0] rem_nxt;
  logic take;

  // restoring division, remainder only
  assign trial = {rem_r, dvd_r[63]};
  assign take = trial >= {1'b0, divisor};
  assign rem_nxt = take ? (trial - {1'b0, divisor}) : trial;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dvd_r <= 64'h0;
      rem_r <= 16'h0;
      cnt_r <= 7'h0;
      busy_r <= 1'b0;
    end else if (start) begin
      dvd_r <= dividend;
      rem_r <= 16'h0;
      cnt_r <= scpa_pkg::MOD_CNT;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      dvd_r <= {dvd_r[62:0], 1'b0};
      rem_r <= rem_nxt[15:0];
      cnt_r <= cnt_r - 7'h1;
      busy_r <= (cnt_r != 7'h1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && !start && (cnt_r == 7'h1);
    end
  end

  assign done = done_r;
  assign remainder = rem_r;

endmodule

// *** hdl/scpa_pkg.sv ***
package scpa_pkg;

  // master clock cycles per seconds-count step
  localparam logic [31:0] MCLK_PER_SEC = 32'h009c4000;

  // recommended symbol ratios, numerator and denominator
  localparam logic [15:0] EURO_M = 16'h0365;
  localparam logic [15:0] EURO_N = 16'h0500;
  localparam logic [15:0] QAM64_M = 16'h0191;
  localparam logic [15:0] QAM64_N = 16'h032c;
  localparam logic [15:0] QAM256_M = 16'h004e;
  localparam logic [15:0] QAM256_N = 16'h0095;

  // reduced formula constants for the two awkward denominators
  localparam logic [15:0] N812_PRE_MOD = 16'h00cb;
  localparam logic [15:0] N812_MUL = 16'h02a8;
  localparam logic [15:0] N149_PRE_MOD = 16'h0095;
  localparam logic [15:0] N149_MUL = 16'h007c;

  // correction added once the seconds count has wrapped
  localparam logic [15:0] ROLL_812 = 16'h004a;
  localparam logic [15:0] ROLL_149 = 16'h0081;

  // serial modulo unit: one dividend bit per cycle
  localparam int MOD_CYC = 64;
  localparam logic [6:0] MOD_CNT = 7'(MOD_CYC);
  // cycles from the update strobe to the phase landing on zero for a zero count;
  // each pass costs MOD_CYC + 2 cycles, start and done handover included
  localparam logic [15:0] ALIGN_LAT = 16'(3 * (MOD_CYC + 2) + 2);

  localparam logic [31:0] TS_RESET = 32'h00000000;

  typedef struct packed {
    logic [15:0] m;
    logic [15:0] n;
  } scpa_ratio_t;

  typedef enum logic [1:0] {
    SEL_EURO = 2'h0,
    SEL_QAM64 = 2'h1,
    SEL_QAM256 = 2'h2,
    SEL_CUSTOM = 2'h3
  } scpa_sel_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_P1 = 4'h2,
    ST_P2 = 4'h4,
    ST_P3 = 4'h8
  } scpa_state_t;

endpackage

// *** hdl/scpa_top.sv ***
// Operation
// - symbol clock locked by 16-bit M/N
// - recommended ratios selectable by code
// - 32-bit timestamp counts every cycle, wraps
// - seconds zero marks symbol positive crossing
// - remaining = seconds*10240000 mod N
// - remainder counts down to generator restart
// - denominator 1280 gives remaining zero
// - N=812: mod 203, times 680, mod 812
// - N=149: mod 149, times 124, mod 149
// - rollover term 74 or 129
// - rollover applied only after seconds wrap
`timescale 1ns/1ps
module scpa_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] sec_count,
  input wire logic sec_upd,
  input wire scpa_pkg::scpa_sel_t ratio_sel,
  input wire scpa_pkg::scpa_ratio_t ratio_custom,
  output logic [31:0] timestamp,
  output logic sym_clk,
  output logic sym_zero,
  output logic gen_restart,
  output logic [15:0] remain_cnt,
  output logic align_done,
  output logic align_busy,
  output logic upd_refused,
  output logic rollover_on
);

  // modulo step used for both the phase counter and the M/N accumulator
  function automatic logic [15:0] mod_add(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] n);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, n}) begin
      s = s - {1'b0, n};
    end
    return s[15:0];
  endfunction

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // timestamp counter
  logic [31:0] ts_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ts_r <= scpa_pkg::TS_RESET;
    end else begin
      ts_r <= ts_r + 32'h1;
    end
  end

  // ratio selection
  scpa_pkg::scpa_ratio_t sel_ratio;

  assign sel_ratio = (ratio_sel == scpa_pkg::SEL_EURO) ?
                       {scpa_pkg::EURO_M, scpa_pkg::EURO_N} :
                     (ratio_sel == scpa_pkg::SEL_QAM64) ?
                       {scpa_pkg::QAM64_M, scpa_pkg::QAM64_N} :
                     (ratio_sel == scpa_pkg::SEL_QAM256) ?
                       {scpa_pkg::QAM256_M, scpa_pkg::QAM256_N} : ratio_custom;

  // seconds wrap tracking
  logic [31:0] sec_last_r;
  logic roll_on_r;
  logic sec_wrap;

  // wrap seen when all-ones steps to zero
  assign sec_wrap = sec_upd && (sec_last_r == 32'hffffffff) && (sec_count == 32'h0);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sec_last_r <= 32'h0;
      roll_on_r <= 1'b0;
    end else if (sec_upd) begin
      sec_last_r <= sec_count;
      roll_on_r <= roll_on_r | sec_wrap;
    end
  end

  // sequencer
  scpa_pkg::scpa_state_t state_r;
  scpa_pkg::scpa_state_t state_nxt;
  logic start_nxt;
  logic start_r;
  logic mod_done;
  logic [15:0] mod_rem;
  logic upd_ok;

  // a zero denominator cannot be aligned; the update is dropped
  assign upd_ok = sec_upd && (sel_ratio.n != 16'h0);

  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    unique case (state_r)
      scpa_pkg::ST_IDLE: begin
        if (upd_ok) begin
          state_nxt = scpa_pkg::ST_P1;
          start_nxt = 1'b1;
        end
      end
      scpa_pkg::ST_P1: begin
        if (mod_done) begin
          state_nxt = scpa_pkg::ST_P2;
          start_nxt = 1'b1;
        end
      end
      scpa_pkg::ST_P2: begin
        if (mod_done) begin
          state_nxt = scpa_pkg::ST_P3;
          start_nxt = 1'b1;
        end
      end
      scpa_pkg::ST_P3: begin
        if (mod_done) begin
          state_nxt = scpa_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = scpa_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= scpa_pkg::ST_IDLE;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_r <= start_nxt;
    end
  end

  // captured operands for one alignment
  logic [31:0] sec_cap_r;
  scpa_pkg::scpa_ratio_t cap_ratio_r;
  logic roll_cap_r;
  logic [15:0] x_r;
  logic [15:0] rem_r;
  logic cap_now;

  assign cap_now = (state_r == scpa_pkg::ST_IDLE) && upd_ok;

  // seconds value taken with its update strobe
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sec_cap_r <= 32'h0;
      cap_ratio_r <= {scpa_pkg::EURO_M, scpa_pkg::EURO_N};
      roll_cap_r <= 1'b0;
    end else if (cap_now) begin
      sec_cap_r <= sec_count;
      cap_ratio_r <= sel_ratio;
      // correction from the wrap itself onward
      roll_cap_r <= roll_on_r | sec_wrap;
    end
  end

  logic is_812;
  logic is_149;
  logic is_1280;
  logic [15:0] roll_term;
  logic [63:0] p1_dvd;
  logic [15:0] p1_div;
  logic [63:0] p2_dvd;
  logic [63:0] p3_dvd;
  logic [63:0] mod_dvd;
  logic [15:0] mod_div;

  assign is_812 = cap_ratio_r.n == scpa_pkg::QAM64_N;
  assign is_149 = cap_ratio_r.n == scpa_pkg::QAM256_N;
  assign is_1280 = cap_ratio_r.n == scpa_pkg::EURO_N;

  assign roll_term = !roll_cap_r ? 16'h0 :
                     is_812 ? scpa_pkg::ROLL_812 :
                     is_149 ? scpa_pkg::ROLL_149 : 16'h0;

  // first pass reduces seconds plus rollover
  // other denominators reduce the full product
  assign p1_dvd = (is_812 || is_149) ?
                    (64'(sec_cap_r) + 64'(roll_term)) :
                    (64'(sec_cap_r) * 64'(scpa_pkg::MCLK_PER_SEC));
  assign p1_div = is_812 ? scpa_pkg::N812_PRE_MOD :
                  is_149 ? scpa_pkg::N149_PRE_MOD : cap_ratio_r.n;

  // second pass scales (N=812 or N=149 only) and reduces by N
  assign p2_dvd = is_812 ? (64'(x_r) * 64'(scpa_pkg::N812_MUL)) :
                  is_149 ? (64'(x_r) * 64'(scpa_pkg::N149_MUL)) : 64'(x_r);

  // count left after the fixed pipeline latency, modulo N
  assign p3_dvd = 64'(rem_r) + (64'(cap_ratio_r.n) * 64'(scpa_pkg::ALIGN_LAT))
                  - 64'(scpa_pkg::ALIGN_LAT);

  assign mod_dvd = (state_r == scpa_pkg::ST_P1) ? p1_dvd :
                   (state_r == scpa_pkg::ST_P2) ? p2_dvd : p3_dvd;
  assign mod_div = (state_r == scpa_pkg::ST_P1) ? p1_div : cap_ratio_r.n;

  scpa_mod_serial u_mod (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .start(start_r),
    .dividend(mod_dvd),
    .divisor(mod_div),
    .done(mod_done),
    .remainder(mod_rem)
  );

  logic load_now;

  assign load_now = (state_r == scpa_pkg::ST_P3) && mod_done;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      x_r <= 16'h0;
      rem_r <= 16'h0;
    end else if (mod_done) begin
      if (state_r == scpa_pkg::ST_P1) begin
        x_r <= mod_rem;
      end
      if (state_r == scpa_pkg::ST_P2) begin
        // whole number of divide periods per second
        rem_r <= is_1280 ? 16'h0 : mod_rem;
      end
    end
  end

  // symbol clock generator
  scpa_pkg::scpa_ratio_t gen_ratio_r;
  logic [15:0] cd_r;
  logic cd_act_r;
  logic [15:0] phase_r;
  logic [15:0] acc_r;
  logic restart_now;
  logic [15:0] phase_nxt;
  logic [15:0] acc_nxt;
  logic sym_clk_nxt;

  // countdown loaded with the compensated remainder
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cd_r <= 16'h0;
      cd_act_r <= 1'b0;
      gen_ratio_r <= {scpa_pkg::EURO_M, scpa_pkg::EURO_N};
    end else if (load_now) begin
      cd_r <= mod_rem;
      cd_act_r <= 1'b1;
      gen_ratio_r <= cap_ratio_r;
    end else if (cd_act_r) begin
      cd_r <= cd_r - 16'h1;
      cd_act_r <= (cd_r != 16'h0);
    end
  end

  // reset pulse at the end of the countdown
  assign restart_now = cd_act_r && (cd_r == 16'h0);

  // phase zero is the positive crossing
  assign phase_nxt = restart_now ? 16'h0 : mod_add(phase_r, 16'h1, gen_ratio_r.n);

  // M/N accumulator gives M symbol cycles per N master cycles
  assign acc_nxt = (phase_nxt == 16'h0) ? 16'h0 : mod_add(acc_r, gen_ratio_r.m, gen_ratio_r.n);
  assign sym_clk_nxt = acc_nxt < {1'b0, gen_ratio_r.n[15:1]};

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r <= 16'h0;
      acc_r <= 16'h0;
    end else begin
      phase_r <= phase_nxt;
      acc_r <= acc_nxt;
    end
  end

  // registered outputs
  logic sym_clk_r;
  logic sym_zero_r;
  logic restart_r;
  logic [15:0] remain_r;
  logic done_r;
  logic busy_r;
  logic refused_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sym_clk_r <= 1'b0;
      sym_zero_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      sym_clk_r <= sym_clk_nxt;
      sym_zero_r <= phase_nxt == 16'h0;
      restart_r <= restart_now;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      remain_r <= 16'h0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (load_now) begin
        remain_r <= rem_r;
      end
      done_r <= load_now;
      busy_r <= state_nxt != scpa_pkg::ST_IDLE;
      refused_r <= sec_upd && !cap_now;
    end
  end

  assign timestamp = ts_r;
  assign sym_clk = sym_clk_r;
  assign sym_zero = sym_zero_r;
  assign gen_restart = restart_r;
  assign remain_cnt = remain_r;
  assign align_done = done_r;
  assign align_busy = busy_r;
  assign upd_refused = refused_r;
  assign rollover_on = roll_on_r;

endmodule

// *** tb/scpa_client.sv ***
`timescale 1ns/1ps
module scpa_client (
  input wire logic clk_sys,
  output logic [31:0] sec_count,
  output logic sec_upd
);
  initial begin
    sec_count = 32'h0;
    sec_upd = 1'b0;
  end
  // new seconds value with one-cycle strobe
  task automatic push(input logic [31:0] s);
    @(posedge clk_sys);
    #1;
    sec_count = s;
    sec_upd = 1'b1;
    @(posedge clk_sys);
    #1;
    sec_upd = 1'b0;
  endtask
endmodule

// *** tb/scpa_top_assertions.sv ***
`timescale 1ns/1ps
module scpa_top_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] sec_count,
  input wire logic sec_upd,
  input wire scpa_pkg::scpa_sel_t ratio_sel,
  input wire logic [31:0] timestamp,
  input wire logic sym_clk,
  input wire logic sym_zero,
  input wire logic gen_restart,
  input wire logic [15:0] remain_cnt,
  input wire logic align_done,
  input wire logic align_busy,
  input wire logic upd_refused,
  input wire logic rollover_on
);
  logic [2:0] up_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ts_step: assert property (
    up_r > 3'h4 |-> timestamp == $past(timestamp) + 32'h1) else $error("timestamp stalled");
  a_done_latency: assert property (
    $rose(align_busy) |-> ##198 align_done) else $error("align_done late or early");
  a_busy_cause: assert property (
    $rose(align_busy) |-> $past(sec_upd)) else $error("busy without update");
  a_refuse_cause: assert property (
    upd_refused |-> $past(sec_upd) && !align_done) else $error("refusal without update");
  a_restart_crossing: assert property (
    gen_restart |-> sym_zero && sym_clk) else $error("restart without crossing");
  a_zero_pulse: assert property (
    sym_zero |=> !sym_zero) else $error("crossing pulse too long");
  a_roll_sticky: assert property (
    rollover_on |=> rollover_on) else $error("rollover flag cleared");
  a_roll_cause: assert property (
    $rose(rollover_on) |-> $past(sec_upd) && $past(sec_count) == 32'h0)
    else $error("rollover without wrap");
  a_euro_zero: assert property (
    align_done && $past(ratio_sel, 199) == scpa_pkg::SEL_EURO |-> remain_cnt == 16'h0)
    else $error("nonzero remainder for 1280");
  a_done_end: assert property (
    align_done |-> $past(align_busy) && !align_busy) else $error("done while busy");
endmodule
bind scpa_top scpa_top_assertions u_chk (.clk_sys, .resetn, .sec_count, .sec_upd,
  .ratio_sel, .timestamp, .sym_clk, .sym_zero, .gen_restart, .remain_cnt, .align_done,
  .align_busy, .upd_refused, .rollover_on);

// *** tb/scpa_top_tb_top.sv ***
`timescale 1ns/1ps
module scpa_top_tb_top;
  logic clk_sys, resetn, sec_upd, sym_clk, sym_zero, gen_restart;
  logic align_done, align_busy, upd_refused, rollover_on;
  logic [31:0] sec_count, timestamp;
  logic [15:0] remain_cnt;
  scpa_pkg::scpa_sel_t ratio_sel;
  scpa_pkg::scpa_ratio_t ratio_custom;
  int errors;
  int tests_run;
  scpa_client u_cli (.clk_sys(clk_sys), .sec_count(sec_count), .sec_upd(sec_upd));
  scpa_top DUT (.clk_sys(clk_sys), .resetn(resetn), .sec_count(sec_count),
    .sec_upd(sec_upd), .ratio_sel(ratio_sel), .ratio_custom(ratio_custom),
    .timestamp(timestamp), .sym_clk(sym_clk), .sym_zero(sym_zero),
    .gen_restart(gen_restart), .remain_cnt(remain_cnt), .align_done(align_done),
    .align_busy(align_busy), .upd_refused(upd_refused), .rollover_on(rollover_on));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // plain long-hand remainder, independent of the reduced forms
  function automatic logic [15:0] exp_rem(input logic [31:0] s, input logic [15:0] n);
    return 16'((64'(s) * 64'h9c4000) % 64'(n));
  endfunction
  task automatic align(input scpa_pkg::scpa_sel_t sel, input logic [15:0] n,
                       input logic [31:0] s, input logic [15:0] exp);
    int d;
    ratio_sel = sel;
    u_cli.push(s);
    d = 1;
    while (gen_restart !== 1'b1 && d < 1700) begin
      @(posedge clk_sys);
      #1;
      d++;
      if (d == 198) begin
        check("align_busy", 32'h1, 32'(align_busy));
      end
      if (d == 199) begin
        check("align_done", 32'h1, 32'(align_done));
        check("remain_cnt", 32'(exp), 32'(remain_cnt));
      end
    end
    check("restart_seen", 32'h1, 32'(gen_restart));
    check("sym_zero_at_restart", 32'h1, 32'(sym_zero));
    check("sym_clk_at_restart", 32'h1, 32'(sym_clk));
    check("restart_phase", 32'(exp % n), 32'(d % int'(n)));
    check("restart_after_done", 32'h1, 32'(d > 199));
    repeat (n) @(posedge clk_sys);
    #1;
    check("sym_zero_period", 32'h1, 32'(sym_zero));
  endtask
  task automatic t_ratios();
    align(scpa_pkg::SEL_EURO, 16'h0500, 32'h0001e240, 16'h0);
    align(scpa_pkg::SEL_QAM64, 16'h032c, 32'h5, exp_rem(32'h5, 16'h032c));
    align(scpa_pkg::SEL_QAM256, 16'h0095, 32'h0001e240, 16'h0087);
    ratio_custom = {16'h004e, 16'h0095};
    align(scpa_pkg::SEL_CUSTOM, 16'h0095, 32'h7, exp_rem(32'h7, 16'h0095));
  endtask
  task automatic t_refuse();
    ratio_sel = scpa_pkg::SEL_QAM64;
    u_cli.push(32'h9);
    repeat (10) @(posedge clk_sys);
    u_cli.push(32'ha);
    check("upd_refused_busy", 32'h1, 32'(upd_refused));
    repeat (200) @(posedge clk_sys);
    #1;
    ratio_custom = '0;
    ratio_sel = scpa_pkg::SEL_CUSTOM;
    u_cli.push(32'h3);
    check("upd_refused_n0", 32'h1, 32'(upd_refused));
    check("busy_n0", 32'h0, 32'(align_busy));
  endtask
  task automatic t_roll();
    align(scpa_pkg::SEL_QAM256, 16'h0095, 32'hffffffff,
          exp_rem(32'hffffffff, 16'h0095));
    check("rollover_before", 32'h0, 32'(rollover_on));
    // 129*124 mod 149 = 53
    align(scpa_pkg::SEL_QAM256, 16'h0095, 32'h0, 16'h0035);
    check("rollover_after", 32'h1, 32'(rollover_on));
    // (1+74)*680 mod 812 = 656
    align(scpa_pkg::SEL_QAM64, 16'h032c, 32'h1, 16'h0290);
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    ratio_sel = scpa_pkg::SEL_EURO;
    ratio_custom = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("timestamp_reset", 32'h0, timestamp);
    resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_ratios();
    t_refuse();
    t_roll();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
endmodule
